// *** hdl/sbi_engine.v ***
// Single-bit two-wire bus engine with AXI4-Lite register access
// Function
// - Arbitration loss set only while transmit-active; it clears transmit-active.
// - Loss when our 1 or repeated start sees SDA low, or foreign start.
// - Master loss: repeated start preempted by SCL low, or stop blocked by 0.
// - Start-seen set for master or non-idle slave, not for idle slave wake.
// - Stop-seen set for master or non-idle slave; idle slave ignores stop.
// - Become master when request set and bus free since reset, time-out or stop.
// - Leave master on arbitration loss, or on stop sent with request cleared.
// - Data write or control write with send-start/stop sets transmit-active.
// - SDA driven low only while transmit-active, in sequencer start/hold, or in low state while SCL reads high; no loss flagged without transmit-active.
// - Data read or clear-transmit-active write clears transmit-active.
// - Idle write ignores bus until next start; stop may promote to master.
// - Clear bits written as 1 clear their flag; 0 does nothing.
// - SCL held low while any of the four attention flags is set.
// - Repeated start: release SDA in SCL low, min time after rise pull low.
// - First start generated automatically on gaining mastership.
// - Stop: SDA low in SCL low, min time after rise release SDA.
// - New transmit bit reaches SDA only while SCL is low.
// - Disabled interface holds bus timer cleared.
// - Enabled without timer-run: only low timer bits count, no hang check.
// - Enabled with timer-run: timer counts in frames, reloaded by edges, start, stop.
// - Timer preloaded with 8 minus min count; min time done at 8.
// - Timing select gives counts 7,6,5,4 and time-outs 1023..1020.
// - Attention reads 1 when any of the four flags is set.
// - Data-ready set on SCL rise unless idle slave; cleared by data access.
// - Timer carry resets interface, releases SCL, raises timer request if enabled.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sbi_regs.vh"

module sbi_engine #(
  parameter TMR_W = 10
) (
  // Clock and reset
  input  wire        SYS_CLK_I,
  input  wire        RST_I,
  // AXI4-Lite write address and data
  input  wire [3:0]  AXI_AWADDR_I,
  input  wire        AXI_AWVALID_I,
  output wire        AXI_AWREADY_O,
  input  wire [31:0] AXI_WDATA_I,
  input  wire [3:0]  AXI_WSTRB_I,
  input  wire        AXI_WVALID_I,
  output wire        AXI_WREADY_O,
  // AXI4-Lite write response
  output reg  [1:0]  AXI_BRESP_O,
  output reg         AXI_BVALID_O,
  input  wire        AXI_BREADY_I,
  // AXI4-Lite read
  input  wire [3:0]  AXI_ARADDR_I,
  input  wire        AXI_ARVALID_I,
  output wire        AXI_ARREADY_O,
  output reg  [31:0] AXI_RDATA_O,
  output reg  [1:0]  AXI_RRESP_O,
  output reg         AXI_RVALID_O,
  input  wire        AXI_RREADY_I,
  // Two-wire bus, open drain
  input  wire        SCL_I,
  output wire        SCL_O,
  output reg         SCL_OE_O,
  input  wire        SDA_I,
  output wire        SDA_O,
  output reg         SDA_OE_O,
  // Timer request
  output reg         TIMER_IRQ_O
);

  // ==========================================================
  // Master sequencer states
  localparam [4:0] M_IDLE  = 5'h01;
  localparam [4:0] M_START = 5'h02;
  localparam [4:0] M_LOW   = 5'h04;
  localparam [4:0] M_HIGH  = 5'h08;
  localparam [4:0] M_HOLD  = 5'h10;

  localparam [1:0] OP_NONE = 2'h0;
  localparam [1:0] OP_REP  = 2'h1;
  localparam [1:0] OP_STOP = 2'h2;

  function [3:0] preload;
    input [1:0] ct;
    begin
      case (ct)
        2'b10:   preload = `SBI_MIN_DONE - `SBI_MIN_CT10;
        2'b01:   preload = `SBI_MIN_DONE - `SBI_MIN_CT01;
        2'b00:   preload = `SBI_MIN_DONE - `SBI_MIN_CT00;
        default: preload = `SBI_MIN_DONE - `SBI_MIN_CT11;
      endcase
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  reg  [1:0] scl_sync_q;
  reg  [1:0] sda_sync_q;
  reg        scl_prev_q;
  reg        sda_prev_q;
  wire       scl_s = scl_sync_q[1];
  wire       sda_s = sda_sync_q[1];

  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], SCL_I};
      sda_sync_q <= {sda_sync_q[0], SDA_I};
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ==========================================================
  // State
  reg [7:0] cfg_q;
  reg       data_ready_flag_q, arl_q, str_q, stp_q, rxbit_q;
  reg       master_q, busy_q, idle_q, drop_q;
  reg       txact_q, txbit_q, sda_low_q, scl_low_q;
  reg       tout_q;
  reg [4:0] mst_q;
  reg [1:0] op_q;
  reg       fsm_load;

  wire slave_enable  = cfg_q[`SBI_CFG_SLAVE_ENABLE];
  wire master_request  = cfg_q[`SBI_CFG_MASTER_REQUEST];
  wire enabled = slave_enable | master_request | master_q;
  wire attn    = data_ready_flag_q | arl_q | str_q | stp_q;
  wire listen  = enabled & ~idle_q;

  // ==========================================================
  // Bus timer
  wire min_done;
  wire carry;
  wire tmr_load = scl_rise | scl_fall | start_det | stop_det | fsm_load;

  sbi_bus_timer #(
    .TMR_W      (TMR_W),
    .MC_CLKS    (`SBI_CLKS_PER_MC)
  ) u_timer (
    .clk_i      (SYS_CLK_I),
    .rst_i      (RST_I),
    .enable_i   (enabled),
    .run_full_i (cfg_q[`SBI_CFG_TIMER_RUN_ENABLE] & busy_q),
    .load_i     (tmr_load),
    .load_val_i (preload({cfg_q[`SBI_CFG_CTHI], cfg_q[`SBI_CFG_CTLO]})),
    .min_done_o (min_done),
    .carry_o    (carry)
  );

  // ==========================================================
  // AXI4-Lite slave
  wire       wr_go = AXI_AWVALID_I & AXI_WVALID_I & ~AXI_BVALID_O;
  wire       rd_go = AXI_ARVALID_I & ~AXI_RVALID_O;
  wire       wr_lo = wr_go & AXI_WSTRB_I[0];
  wire [7:0] wd    = AXI_WDATA_I[7:0];
  wire       wr_ctrl = wr_lo & (AXI_AWADDR_I == `SBI_ADDR_CTRL);
  wire       wr_data = wr_lo & (AXI_AWADDR_I == `SBI_ADDR_DATA);
  wire       wr_cfg  = wr_lo & (AXI_AWADDR_I == `SBI_ADDR_CFG);
  wire       wr_tout = wr_lo & (AXI_AWADDR_I == `SBI_ADDR_TOUT);
  wire       rd_data = rd_go & (AXI_ARADDR_I == `SBI_ADDR_DATA);
  wire       aw_hit  = (AXI_AWADDR_I[1:0] == 2'h0);
  wire       ar_hit  = (AXI_ARADDR_I[1:0] == 2'h0);

  assign AXI_AWREADY_O = wr_go;
  assign AXI_WREADY_O  = wr_go;
  assign AXI_ARREADY_O = rd_go;

  reg [7:0] rd_val;
  always @* begin
    case (AXI_ARADDR_I)
      `SBI_ADDR_CTRL: rd_val = {rxbit_q, attn, data_ready_flag_q, arl_q, str_q, stp_q, master_q, txact_q};
      `SBI_ADDR_DATA: rd_val = {rxbit_q, 7'h00};
      `SBI_ADDR_CFG:  rd_val = cfg_q;
      `SBI_ADDR_TOUT: rd_val = {7'h00, tout_q};
      default:        rd_val = 8'h00;
    endcase
  end

  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      AXI_BVALID_O <= 1'b0;
      AXI_BRESP_O  <= `SBI_RESP_OKAY;
      AXI_RVALID_O <= 1'b0;
      AXI_RRESP_O  <= `SBI_RESP_OKAY;
      AXI_RDATA_O  <= 32'h00000000;
    end else begin
      if (wr_go) begin
        AXI_BVALID_O <= 1'b1;
        AXI_BRESP_O  <= aw_hit ? `SBI_RESP_OKAY : `SBI_RESP_SLVERR;
      end else if (AXI_BREADY_I) begin
        AXI_BVALID_O <= 1'b0;
      end
      if (rd_go) begin
        AXI_RVALID_O <= 1'b1;
        AXI_RRESP_O  <= ar_hit ? `SBI_RESP_OKAY : `SBI_RESP_SLVERR;
        AXI_RDATA_O  <= {24'h000000, rd_val};
      end else if (AXI_RREADY_I) begin
        AXI_RVALID_O <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Arbitration loss detection
  wire arl_c1 = scl_rise & ~sda_low_q & ~sda_s;
  wire arl_c2 = start_det & ~sda_low_q;
  wire arl_c3 = (mst_q == M_HIGH) & (op_q == OP_REP) & scl_fall;
  wire arl_c4 = (mst_q == M_HOLD) & (op_q == OP_STOP) & min_done & ~fsm_load & ~sda_s;
  wire arl_set = listen & txact_q & (arl_c1 | arl_c2 | arl_c3 | arl_c4);

  // ==========================================================
  // Flags, configuration and mastership
  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cfg_q    <= 8'h00;
      data_ready_flag_q   <= 1'b0;
      arl_q    <= 1'b0;
      str_q    <= 1'b0;
      stp_q    <= 1'b0;
      rxbit_q  <= 1'b0;
      master_q <= 1'b0;
      busy_q   <= 1'b0;
      idle_q   <= 1'b0;
      drop_q   <= 1'b0;
      txact_q  <= 1'b0;
      txbit_q  <= 1'b1;
      tout_q   <= 1'b0;
      TIMER_IRQ_O <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_q <= wd & `SBI_CFG_MASK;
      end
      // Time-out wins over a same-cycle clear write
      tout_q      <= carry | (tout_q & ~(wr_tout & wd[`SBI_TOUT_FLAG]));
      TIMER_IRQ_O <= tout_q & cfg_q[`SBI_CFG_TIRQEN];
      if (scl_rise) begin
        rxbit_q <= sda_s;
      end
      if (carry) begin
        // Hang: drop everything on the bus side and release both lines
        data_ready_flag_q   <= 1'b0;
        arl_q    <= 1'b0;
        str_q    <= 1'b0;
        stp_q    <= 1'b0;
        master_q <= 1'b0;
        busy_q   <= 1'b0;
        idle_q   <= 1'b0;
        drop_q   <= 1'b0;
        txact_q  <= 1'b0;
      end else begin
        // Hardware set wins over a same-cycle clear
        data_ready_flag_q <= (scl_rise & listen) |
                  (data_ready_flag_q & ~(wr_ctrl & wd[`SBI_WR_CDR]) & ~wr_data & ~rd_data);
        arl_q  <= arl_set | (arl_q & ~(wr_ctrl & wd[`SBI_WR_CLEAR_ARB_LOSS]));
        str_q  <= (start_det & listen) |
                  (str_q & ~(wr_ctrl & wd[`SBI_WR_CLEAR_START_SEEN]));
        stp_q  <= (stop_det & listen) |
                  (stp_q & ~(wr_ctrl & wd[`SBI_WR_CLEAR_STOP_SEEN]));
        if (start_det) begin
          busy_q <= 1'b1;
          idle_q <= 1'b0;
        end else if (stop_det) begin
          busy_q <= 1'b0;
        end else if (wr_ctrl & wd[`SBI_WR_IDLE]) begin
          idle_q <= 1'b1;
        end
        // Transmit-active
        if (arl_set) begin
          txact_q <= 1'b0;
        end else if (wr_data) begin
          txact_q <= 1'b1;
          txbit_q <= wd[`SBI_DAT_BIT];
        end else if (wr_ctrl & wd[`SBI_WR_SEND_REPEATED_START]) begin
          txact_q <= 1'b1;
          txbit_q <= 1'b1;
        end else if (wr_ctrl & wd[`SBI_WR_SEND_STOP]) begin
          txact_q <= 1'b1;
          txbit_q <= 1'b0;
        end else if (rd_data | (wr_ctrl & wd[`SBI_WR_CXA])) begin
          txact_q <= 1'b0;
        end
        // Mastership
        if (wr_ctrl & wd[`SBI_WR_SEND_STOP] & ~master_request) begin
          drop_q <= 1'b1;
        end
        if (arl_set | (stop_det & drop_q)) begin
          master_q <= 1'b0;
          drop_q   <= 1'b0;
        end else if (master_request & ~busy_q & ~start_det) begin
          master_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Line drivers and master sequencer
  wire sda_tgt = txact_q & ~txbit_q;
  wire sda_apply = ~scl_s & (mst_q != M_START) & (mst_q != M_HOLD);

  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mst_q     <= M_IDLE;
      op_q      <= OP_NONE;
      sda_low_q <= 1'b0;
      scl_low_q <= 1'b0;
      fsm_load  <= 1'b0;
    end else begin
      fsm_load <= 1'b0;
      if (wr_ctrl & wd[`SBI_WR_SEND_REPEATED_START]) begin
        op_q <= OP_REP;
      end else if (wr_ctrl & wd[`SBI_WR_SEND_STOP]) begin
        op_q <= OP_STOP;
      end
      if (sda_apply) begin
        sda_low_q <= sda_tgt;
      end
      if (carry | arl_set | ~master_q) begin
        mst_q     <= M_IDLE;
        scl_low_q <= 1'b0;
        if (carry | arl_set) begin
          sda_low_q <= 1'b0;
          op_q      <= OP_NONE;
        end
      end else begin
        case (mst_q)
          M_IDLE: begin
            // Automatic first start once the bus has been free long enough
            if (~busy_q & min_done & scl_s & sda_s) begin
              sda_low_q <= 1'b1;
              fsm_load  <= 1'b1;
              mst_q     <= M_START;
            end
          end
          M_START: begin
            if (min_done & ~fsm_load) begin
              scl_low_q <= 1'b1;
              fsm_load  <= 1'b1;
              mst_q     <= M_LOW;
            end
          end
          M_LOW: begin
            // SDA must settle before SCL is let go
            if (min_done & ~attn & ~fsm_load & (sda_low_q == sda_tgt)) begin
              scl_low_q <= 1'b0;
              mst_q     <= M_HIGH;
            end
          end
          M_HIGH: begin
            if (scl_fall) begin
              scl_low_q <= 1'b1;
              mst_q     <= M_LOW;
              if (op_q == OP_REP) begin
                op_q <= OP_NONE;
              end
            end else if (scl_s & ~scl_rise & min_done) begin
              fsm_load <= 1'b1;
              case (op_q)
                OP_REP: begin
                  sda_low_q <= 1'b1;
                  mst_q     <= M_HOLD;
                end
                OP_STOP: begin
                  sda_low_q <= 1'b0;
                  mst_q     <= M_HOLD;
                end
                default: begin
                  scl_low_q <= 1'b1;
                  mst_q     <= M_LOW;
                end
              endcase
            end
          end
          M_HOLD: begin
            if (min_done & ~fsm_load) begin
              fsm_load <= 1'b1;
              op_q     <= OP_NONE;
              if (op_q == OP_REP) begin
                scl_low_q <= 1'b1;
                mst_q     <= M_LOW;
              end else begin
                mst_q <= M_IDLE;
              end
            end
          end
          default: begin
            mst_q <= M_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Pin outputs: open drain, low only when enabled
  always @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      SCL_OE_O <= 1'b0;
      SDA_OE_O <= 1'b0;
    end else begin
      // Stretch: hold SCL once it is low and a flag awaits software
      SCL_OE_O <= enabled & ~carry & (scl_low_q | (attn & ~scl_s));
      SDA_OE_O <= enabled & ~carry & sda_low_q &
                  (txact_q | (mst_q == M_START) | (mst_q == M_HOLD) | ((mst_q == M_LOW) & scl_s));
    end
  end

  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;

endmodule // sbi_engine

`default_nettype wire

// *** hdl/sbi_regs.vh ***
// Register map, field positions and timing constants of the single-bit two-wire engine
`ifndef SBI_REGS_VH
`define SBI_REGS_VH

// ==========================================================
// Register byte offsets
`define SBI_ADDR_CTRL      4'h0
`define SBI_ADDR_DATA      4'h4
`define SBI_ADDR_CFG       4'h8
`define SBI_ADDR_TOUT      4'hC

// ==========================================================
// bus_control_status read fields
`define SBI_RD_RXBIT       7
`define SBI_RD_ATTN        6
`define SBI_RD_DATA_READY_FLAG        5
`define SBI_RD_ARL         4
`define SBI_RD_STR         3
`define SBI_RD_STP         2
`define SBI_RD_MASTER      1
`define SBI_RD_TXACT       0

// bus_control_status write fields
`define SBI_WR_CDR         7
`define SBI_WR_CLEAR_ARB_LOSS        6
`define SBI_WR_CLEAR_START_SEEN        5
`define SBI_WR_CLEAR_STOP_SEEN        4
`define SBI_WR_IDLE        3
`define SBI_WR_CXA         2
`define SBI_WR_SEND_STOP        1
`define SBI_WR_SEND_REPEATED_START        0

// bit_data_register field
`define SBI_DAT_BIT        7

// bus_config_register fields
`define SBI_CFG_SLAVE_ENABLE     7
`define SBI_CFG_MASTER_REQUEST     6
`define SBI_CFG_TIRQEN     5
`define SBI_CFG_TIMER_RUN_ENABLE      4
`define SBI_CFG_CTHI       1
`define SBI_CFG_CTLO       0
`define SBI_CFG_MASK       8'hF3

// Time-out status field, write 1 to clear
`define SBI_TOUT_FLAG      0

// ==========================================================
// Timing: machine cycle length and minimum-time counts
`define SBI_CLKS_PER_MC    6
`define SBI_MIN_DONE       4'h8
`define SBI_MIN_CT00       4'h5
`define SBI_MIN_CT01       4'h6
`define SBI_MIN_CT10       4'h7
`define SBI_MIN_CT11       4'h4

// AXI responses
`define SBI_RESP_OKAY      2'h0
`define SBI_RESP_SLVERR    2'h2

`endif

// *** hdl/sbi_bus_timer.v ***
// Ten-bit bus timer with machine-cycle prescaler for min-time and hang detection
`timescale 1ns/100ps
`default_nettype none
`include "sbi_regs.vh"

module sbi_bus_timer #(
  parameter TMR_W = 10,
  parameter MC_CLKS = `SBI_CLKS_PER_MC
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // Control
  input  wire             enable_i,
  input  wire             run_full_i,
  input  wire             load_i,
  input  wire [3:0]       load_val_i,
  // Status
  output wire             min_done_o,
  output reg              carry_o
);

  reg [2:0]       pre_q;
  reg [TMR_W-1:0] cnt_q;
  wire            tick = (pre_q == MC_CLKS[2:0] - 3'h1);

  // ==========================================================
  // Prescaler: one tick per machine cycle
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_q <= 3'h0;
    end else if (!enable_i || tick) begin
      pre_q <= 3'h0;
    end else begin
      pre_q <= pre_q + 3'h1;
    end
  end

  // ==========================================================
  // Counter
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q   <= {TMR_W{1'b0}};
      carry_o <= 1'b0;
    end else begin
      carry_o <= 1'b0;
      if (!enable_i) begin
        cnt_q <= {TMR_W{1'b0}};
      end else if (load_i) begin
        cnt_q <= {{(TMR_W-4){1'b0}}, load_val_i};
      end else if (tick) begin
        if (run_full_i) begin
          {carry_o, cnt_q} <= {1'b0, cnt_q} + {{TMR_W{1'b0}}, 1'b1};
        end else if (cnt_q[TMR_W-1:3] == {(TMR_W-3){1'b0}}) begin
          // Only the low bits run; stops at the min-time mark, no hang check
          cnt_q <= cnt_q + {{(TMR_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  assign min_done_o = (cnt_q[TMR_W-1:3] != {(TMR_W-3){1'b0}});

endmodule // sbi_bus_timer

`default_nettype wire

// *** tb/sbi_engine_asserts.sv ***
// Port-level checks of the single-bit two-wire engine
`timescale 1ns/100ps
`default_nettype none
`include "sbi_regs.vh"
module sbi_engine_asserts #(
  parameter TMR_W = 10
) (
  // Clock and reset
  input wire logic        SYS_CLK_I,
  input wire logic        RST_I,
  // Register bus
  input wire logic [3:0]  AXI_AWADDR_I,
  input wire logic        AXI_AWVALID_I,
  input wire logic        AXI_AWREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0]  AXI_WSTRB_I,
  input wire logic        AXI_WVALID_I,
  input wire logic [1:0]  AXI_BRESP_O,
  input wire logic        AXI_BVALID_O,
  input wire logic        AXI_BREADY_I,
  input wire logic [3:0]  AXI_ARADDR_I,
  input wire logic        AXI_ARVALID_I,
  input wire logic [31:0] AXI_RDATA_O,
  input wire logic        AXI_RVALID_O,
  input wire logic        AXI_RREADY_I,
  // Lines and request
  input wire logic        SCL_O,
  input wire logic        SDA_O,
  input wire logic        TIMER_IRQ_O
);
  // ==========================================================
  // Helpers
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);
  wire  wr_take = AXI_AWVALID_I & AXI_WVALID_I & ~AXI_BVALID_O;
  wire  rd_take = AXI_ARVALID_I & ~AXI_RVALID_O;
  wire  to_clr  = wr_take & (AXI_AWADDR_I == `SBI_ADDR_TOUT) & AXI_WSTRB_I[0] & AXI_WDATA_I[0];
  logic rd_ctl_q;
  // Which register the pending read answer comes from
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rd_ctl_q <= 1'b0;
    end else if (rd_take) begin
      rd_ctl_q <= (AXI_ARADDR_I == `SBI_ADDR_CTRL);
    end
  end
  // ==========================================================
  // Properties
  wr_answer_a: assert property (wr_take |=> AXI_BVALID_O) else $error("write answer late");
  rd_answer_a: assert property (rd_take |=> AXI_RVALID_O) else $error("read answer late");
  wr_once_a: assert property (AXI_BVALID_O && AXI_BREADY_I |=> !AXI_BVALID_O) else $error("write answered twice");
  rd_once_a: assert property (AXI_RVALID_O && AXI_RREADY_I |=> !AXI_RVALID_O) else $error("read answered twice");
  wr_ready_a: assert property (AXI_AWREADY_O == wr_take) else $error("write ready wrong");
  bad_addr_a: assert property (wr_take && AXI_AWADDR_I[1:0] != 2'h0 |=> AXI_BRESP_O == `SBI_RESP_SLVERR)
    else $error("unaligned write not refused");
  attn_sum_a: assert property (AXI_RVALID_O && rd_ctl_q |-> AXI_RDATA_O[6] == |AXI_RDATA_O[5:2])
    else $error("attention bit disagrees with flags");
  rd_top_a: assert property (AXI_RVALID_O |-> AXI_RDATA_O[31:8] == 24'h0) else $error("read upper bits set");
  open_drain_a: assert property (!SCL_O && !SDA_O) else $error("line driven high");
  irq_clear_a: assert property (to_clr |-> ##2 !TIMER_IRQ_O)
    else $error("timer request not cleared");
  cover property (wr_take && AXI_AWADDR_I[1:0] != 2'h0);
  cover property ($rose(TIMER_IRQ_O));
  cover property (AXI_RVALID_O && rd_ctl_q && AXI_RDATA_O[6]);
endmodule // sbi_engine_asserts
bind sbi_engine sbi_engine_asserts #(.TMR_W(TMR_W)) u_chk (.*);
`default_nettype wire

// *** tb/sbi_far_party.sv ***
// Far-side party on the two-wire bus, open-drain lines with pull-ups
`timescale 1ns/100ps
`default_nettype none
module sbi_far_party (
  // Engine pull enables
  input  wire logic scl_oe_i,
  input  wire logic sda_oe_i,
  // Resolved line levels
  output wire logic scl_o,
  output wire logic sda_o
);
  logic m_scl = 1'b0, m_sda = 1'b0, smp = 1'b0;
  // A line nobody pulls reads high
  assign scl_o = ~(scl_oe_i | m_scl);
  assign sda_o = ~(sda_oe_i | m_sda);
  // Start, then SCL kept low; the 3 ns lead keeps edges off the system clock grid
  task automatic start();
    #3;
    m_sda = 1'b1;
    #80;
    m_scl = 1'b1;
    #77;
  endtask
  // One 160 ns bit; waits while SCL is stretched low by the engine
  task automatic bits(input logic v);
    #3;
    m_sda = ~v;
    #40;
    m_scl = 1'b0;
    wait (scl_o === 1'b1);
    #83;
    smp = sda_o;
    m_scl = 1'b1;
    #34;
  endtask
  // Stop, and leaves both lines released
  task automatic stop();
    #3;
    m_sda = 1'b1;
    #40;
    m_scl = 1'b0;
    wait (scl_o === 1'b1);
    #83;
    m_sda = 1'b0;
    #34;
  endtask
endmodule // sbi_far_party
`default_nettype wire

// *** tb/sbi_engine_tb_top.sv ***
// Register-level bench of the single-bit two-wire engine
`timescale 1ns/100ps
`default_nettype none
`include "sbi_regs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module sbi_engine_tb_top;
  localparam logic [3:0] CT = `SBI_ADDR_CTRL;
  localparam logic [3:0] DT = `SBI_ADDR_DATA;
  localparam logic [3:0] CF = `SBI_ADDR_CFG;
  localparam logic [3:0] TO = `SBI_ADDR_TOUT;
  int          n_errors = 0;
  int          comparisons = 0;
  int          n;
  logic [1:0]  resp;
  logic        SYS_CLK_I = 1'b0, RST_I = 1'b1;
  logic [3:0]  AXI_AWADDR_I = 4'h0, AXI_ARADDR_I = 4'h0, AXI_WSTRB_I = 4'hF;
  logic [31:0] AXI_WDATA_I = 32'h0, AXI_RDATA_O;
  logic        AXI_AWVALID_I = 1'b0, AXI_WVALID_I = 1'b0, AXI_BREADY_I = 1'b0;
  logic        AXI_ARVALID_I = 1'b0, AXI_RREADY_I = 1'b0;
  logic        AXI_AWREADY_O, AXI_WREADY_O, AXI_BVALID_O, AXI_ARREADY_O, AXI_RVALID_O;
  logic [1:0]  AXI_BRESP_O, AXI_RRESP_O;
  logic        SCL_I, SDA_I, SCL_O, SDA_O, SCL_OE_O, SDA_OE_O, TIMER_IRQ_O;
  sbi_engine uut (.*);
  sbi_far_party far (.scl_oe_i(SCL_OE_O), .sda_oe_i(SDA_OE_O), .scl_o(SCL_I), .sda_o(SDA_I));
  always #10 SYS_CLK_I = ~SYS_CLK_I;
  // ==========================================================
  // Register bus tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge SYS_CLK_I);
    AXI_AWADDR_I <= a;
    AXI_WDATA_I <= {24'h0, d};
    AXI_AWVALID_I <= 1'b1;
    AXI_WVALID_I <= 1'b1;
    AXI_BREADY_I <= 1'b1;
    do @(posedge SYS_CLK_I); while (AXI_AWREADY_O !== 1'b1);
    AXI_AWVALID_I <= 1'b0;
    AXI_WVALID_I <= 1'b0;
    do @(posedge SYS_CLK_I); while (AXI_BVALID_O !== 1'b1);
    resp = AXI_BRESP_O;
    AXI_BREADY_I <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge SYS_CLK_I);
    AXI_ARADDR_I <= a;
    AXI_ARVALID_I <= 1'b1;
    AXI_RREADY_I <= 1'b1;
    do @(posedge SYS_CLK_I); while (AXI_ARREADY_O !== 1'b1);
    AXI_ARVALID_I <= 1'b0;
    do @(posedge SYS_CLK_I); while (AXI_RVALID_O !== 1'b1);
    AXI_RREADY_I <= 1'b0;
    `CHK({AXI_RRESP_O, AXI_RDATA_O[7:0] & m}, {`SBI_RESP_OKAY, e})
  endtask
  // Lets the line synchronisers and flag logic catch up
  task automatic st();
    repeat (8) @(posedge SYS_CLK_I);
  endtask
  task automatic results();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    n_errors++;
    results();
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (20) @(posedge SYS_CLK_I);
    RST_I <= 1'b0;
    rc(CT, 8'h00);
    rc(CF, 8'h00);
    // Master request stays clear here: a taken bus is given back only by a stop, an arbitration loss or a time-out
    wr(CF, 8'hBF);
    rc(CF, 8'hB3);
    wr(4'h1, 8'h00);
    `CHK(resp, `SBI_RESP_SLVERR)
    rc(CF, 8'hB3);
    wr(CF, 8'h80);
    far.start();
    st();
    rc(CT, 8'h48);
    `CHK(SCL_OE_O, 1'b1)
    wr(CT, 8'h20);
    st();
    `CHK(SCL_OE_O, 1'b0)
    far.bits(1'b1);
    st();
    rc(CT, 8'hE0);
    rc(DT, 8'h80);
    rc(CT, 8'h80);
    wr(DT, 8'h00);
    rc(CT, 8'h81);
    far.bits(1'b1);
    `CHK(far.smp, 1'b0)
    st();
    rc(CT, 8'h61);
    wr(CT, 8'h84);
    rc(CT, 8'h00);
    wr(DT, 8'h80);
    far.bits(1'b0);
    st();
    rc(CT, 8'h70);
    wr(CT, 8'h00);
    rc(CT, 8'h70);
    wr(CT, 8'h80);
    st();
    `CHK(SCL_OE_O, 1'b1)
    wr(CT, 8'h40);
    st();
    `CHK(SCL_OE_O, 1'b0)
    far.stop();
    st();
    rc(CT, 8'h64);
    wr(CT, 8'h90);
    // Master: automatic start, one bit, then a stop that gives the bus back
    wr(CF, 8'hC0);
    repeat (150) @(posedge SYS_CLK_I);
    rc(CT, 8'h4A);
    `CHK(SCL_OE_O, 1'b1)
    wr(CT, 8'h20);
    repeat (100) @(posedge SYS_CLK_I);
    rc(CT, 8'hE2);
    wr(CF, 8'h80);
    rc(CT, 8'hE2);
    wr(CT, 8'h82);
    repeat (100) @(posedge SYS_CLK_I);
    rc(CT, 8'h65);
    `CHK(SCL_OE_O | SDA_OE_O, 1'b0)
    wr(CT, 8'h94);
    wr(CT, 8'h08);
    far.start();
    st();
    rc(CT, 8'h00);
    far.bits(1'b1);
    st();
    rc(CT, 8'hE0);
    wr(CT, 8'h88);
    far.stop();
    st();
    rc(CT, 8'h00, 8'h7F);
    wr(CF, 8'hB3);
    far.start();
    n = 0;
    // Nobody answers, so the bus timer must cut the frame off
    while (TIMER_IRQ_O !== 1'b1 && n < 8000) begin
      @(posedge SYS_CLK_I);
      n++;
    end
    `CHK((n > 6080) && (n < 6170), 1'b1)
    rc(TO, 8'h01);
    rc(CT, 8'h00, 8'h7F);
    `CHK(SCL_OE_O | SDA_OE_O, 1'b0)
    far.stop();
    wr(TO, 8'h01);
    st();
    `CHK(TIMER_IRQ_O, 1'b0)
    rc(TO, 8'h00);
    results();
  end
endmodule // sbi_engine_tb_top
`default_nettype wire
